// File: inc/sleep_power_pkg.sv
// Package: register map, field positions and reset value of the sleep power control register
package sleep_power_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   // Register offset
   localparam logic [7:0] SLEEP_POWER_CONTROL_OFFSET = 8'h8F;

   // Field positions
   localparam int unsigned BIT_HIBERNATE_SELECT  = 7;
   localparam int unsigned BIT_UNUSED            = 6;
   localparam int unsigned BIT_REFERENCE_OFF     = 5;
   localparam int unsigned BIT_LEVEL_SHIFT_OFF   = 4;
   localparam int unsigned BIT_OSC_SLEEP_STOP    = 3;
   localparam int unsigned BIT_COMPARATOR_OFF    = 2;
   localparam int unsigned BIT_TEMP_SENSOR_OFF   = 1;
   localparam int unsigned BIT_CONVERTER_OFF     = 0;

   // Reset value and writable-bit mask
   localparam logic [7:0] SLEEP_POWER_CONTROL_RESET = 8'h3F;
   localparam logic [7:0] SLEEP_POWER_CONTROL_MASK  = 8'hBF;

   // Register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Analog power-gating controls, active high means off
   typedef struct packed {
      logic reference_power_off;
      logic level_shift_power_off;
      logic comparator_power_off;
      logic temp_sensor_power_off;
      logic converter_power_off;
   } power_ctl_t;

   // Sleep sequencing states
   typedef enum logic [1:0] {
      ST_RUN       = 2'b00,
      ST_SLEEP     = 2'b01,
      ST_HIBERNATE = 2'b10
   } sleep_state_t;

endpackage

// File: rtl/sleep_power_reg.sv
// Storage of the sleep power control register with its fixed-zero bit
`timescale 1ns/1ps
module sleep_power_reg
   import sleep_power_pkg::*;
(
   input  wire logic             clock,   // Core clock
   input  wire logic             rst,     // Async reset, active high
   input  wire logic             wr_en,   // Write this register
   input  wire logic [7:0]       wdata,   // Write data
   output logic      [7:0]       value    // Stored value
);

   logic [7:0] value_q;
   logic [7:0] value_d;

   // Bit 6 never stores; it reads zero
   assign value_d = wr_en ? (wdata & SLEEP_POWER_CONTROL_MASK) : value_q;
   assign value   = value_q;

   // Register, loaded with its power-on value
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         value_q <= SLEEP_POWER_CONTROL_RESET;
      end else begin
         value_q <= value_d;
      end
   end

endmodule // sleep_power_reg

// File: rtl/sleep_power_control_reg.sv
// Sleep power control register bank with analog power gating and sleep oscillator control
`timescale 1ns/1ps
module sleep_power_control_reg
   import sleep_power_pkg::*;
(
   input  wire logic             clock,          // 40 MHz core clock
   input  wire logic             rst,            // Async reset, active high
   input  wire logic [7:0]       addr,           // Register address
   input  wire logic [7:0]       wdata,          // Write data
   input  wire logic             wr,             // Write strobe
   input  wire logic             rd,             // Read strobe
   output logic      [7:0]       rdata,          // Read data, cycle after rd
   input  wire logic             sleep_req,      // Sleep instruction executed, pulse
   input  wire logic             wake_req,       // Wake-up event, pulse
   output power_ctl_t            power_ctl,      // Analog power-off controls
   output logic                  osc_run,        // Main oscillator enable
   output logic                  in_sleep,       // Sleeping (either mode)
   output logic                  in_hibernate    // Hibernating
);

   // True while the sequencer holds the core in either low-power state
   function automatic logic is_asleep(input sleep_state_t s);
      return (s != ST_RUN);
   endfunction

   // True only in the deeper of the two low-power states
   function automatic logic is_hibernating(input sleep_state_t s);
      return (s == ST_HIBERNATE);
   endfunction

   // Low-power state picked by the select bit at the entry edge
   function automatic sleep_state_t entry_state(input logic hibernate);
      return hibernate ? ST_HIBERNATE : ST_SLEEP;
   endfunction

   // Oscillator enable: always awake, in sleep only with the stop bit clear
   function automatic logic osc_enable(input logic asleep, input logic stop);
      return !asleep || !stop;
   endfunction

   // Address match for the one register this bank holds
   function automatic logic addr_hits(input logic [7:0] a);
      return (a == SLEEP_POWER_CONTROL_OFFSET);
   endfunction

   // Read image; the unimplemented bit always returns zero
   function automatic logic [7:0] read_view(input logic [7:0] v);
      return v & SLEEP_POWER_CONTROL_MASK;
   endfunction

   // Power-off set carried by a register image, one bit per analog group
   function automatic power_ctl_t gate_fields(input logic [7:0] v);
      power_ctl_t g;
      g.reference_power_off   = v[BIT_REFERENCE_OFF];
      g.level_shift_power_off = v[BIT_LEVEL_SHIFT_OFF];
      g.comparator_power_off  = v[BIT_COMPARATOR_OFF];
      g.temp_sensor_power_off = v[BIT_TEMP_SENSOR_OFF];
      g.converter_power_off   = v[BIT_CONVERTER_OFF];
      return g;
   endfunction

   // Gate set loaded by reset, taken from the power-on register image
   localparam power_ctl_t POWER_CTL_RESET = gate_fields(SLEEP_POWER_CONTROL_RESET);

   // Bus decode
   reg_req_t   req;
   logic       wr_hit;
   logic       rd_hit;

   // Register image and read path
   logic [7:0] reg_value;
   logic [7:0] read_image;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   // Only the one offset decodes; every other address reads back zero
   assign req        = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wr_hit     = req.wr & addr_hits(req.addr);
   assign rd_hit     = req.rd & addr_hits(req.addr);
   assign read_image = read_view(reg_value);
   assign rdata_d    = rd_hit ? read_image : 8'h00;

   // Register storage; bit 6 is dropped on the way in
   sleep_power_reg u_reg (
      .clock (clock),
      .rst   (rst),
      .wr_en (wr_hit),
      .wdata (req.wdata),
      .value (reg_value)
   );

   // Field extraction
   logic       hibernate_select;
   logic       oscillator_sleep_stop;
   power_ctl_t power_ctl_d;

   // Mode bits: hibernate select for the sleep sequencer, stop bit for the oscillator enable
   assign hibernate_select      = reg_value[BIT_HIBERNATE_SELECT];
   assign oscillator_sleep_stop = reg_value[BIT_OSC_SLEEP_STOP];

   // Analog power gates follow their bits whatever the sleep state
   assign power_ctl_d = gate_fields(reg_value);

   // Sleep state sequencing
   sleep_state_t state_q;
   sleep_state_t state_d;

   // Accepted requests
   logic         sleep_taken;
   logic         wake_taken;

   // A sleep request counts only while running, a wake only while asleep
   assign sleep_taken = sleep_req && !is_asleep(state_q);
   assign wake_taken  = wake_req && is_asleep(state_q);

   // Next state; plain sleep or hibernate is fixed at the entry edge
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (sleep_taken) begin
               state_d = entry_state(hibernate_select);
            end
         end
         ST_SLEEP: begin
            if (wake_taken) begin
               state_d = ST_RUN;
            end
         end
         ST_HIBERNATE: begin
            if (wake_taken) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // Next values of the status outputs, all from the next state
   logic osc_run_d;
   logic sleeping_d;
   logic hibernating_d;

   // Oscillator runs outside sleep; in sleep only when the stop bit is clear
   assign sleeping_d    = is_asleep(state_d);
   assign hibernating_d = is_hibernating(state_d);
   assign osc_run_d     = osc_enable(sleeping_d, oscillator_sleep_stop);

   // Sequencer state register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Read data, standing for the one cycle after the strobe
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Analog power gates, all off after reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         power_ctl <= POWER_CTL_RESET;
      end else begin
         power_ctl <= power_ctl_d;
      end
   end

   // Main oscillator enable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         osc_run <= 1'b1;
      end else begin
         osc_run <= osc_run_d;
      end
   end

   // Sleeping flag, either low-power state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         in_sleep <= 1'b0;
      end else begin
         in_sleep <= sleeping_d;
      end
   end

   // Hibernating flag
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         in_hibernate <= 1'b0;
      end else begin
         in_hibernate <= hibernating_d;
      end
   end

   // Read data leaves straight from its flip-flop
   assign rdata = rdata_q;

endmodule // sleep_power_control_reg

// File: verif/sleep_power_control_reg_properties.sv
// Checker for the sleep power control register
`timescale 1ns/1ps
module sleep_power_control_reg_properties
   import sleep_power_pkg::*;
(
   input wire logic       clock,        // Clock
   input wire logic       rst,          // Reset
   input wire logic [7:0] addr,         // Address
   input wire logic [7:0] wdata,        // Write data
   input wire logic       wr,           // Write
   input wire logic       rd,           // Read
   input wire logic [7:0] rdata,        // Read data
   input wire logic       sleep_req,    // Sleep
   input wire logic       wake_req,     // Wake
   input wire power_ctl_t power_ctl,    // Power-off set
   input wire logic       osc_run,      // Oscillator on
   input wire logic       in_sleep,     // Asleep
   input wire logic       in_hibernate  // Hibernating
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Shadow of what software wrote
   wire        w = wr && addr == 8'h8F;
   wire        r = rd && addr == 8'h8F;
   logic [7:0] sh_q;
   always_ff @(posedge clock or posedge rst)
      if (rst) sh_q <= 8'h3F;
      else if (w) sh_q <= wdata & 8'hBF;
   // Gate output follows stored bit one cycle on
   property p_g(int j, int i);
      power_ctl[j] == $past(sh_q[i]);
   endproperty
   a_ref_gate: assert property (p_g(4, 5)) else $error("ref gate");
   a_shift_gate: assert property (p_g(3, 4)) else $error("shift gate");
   a_cmp_gate: assert property (p_g(2, 2)) else $error("cmp gate");
   a_temp_gate: assert property (p_g(1, 1)) else $error("temp gate");
   a_adc_gate: assert property (p_g(0, 0)) else $error("adc gate");
   a_read_data: assert property (rdata == ($past(r) ? $past(sh_q) : 8'h00)) else $error("rdata");
   a_reset_value: assert property (disable iff (1'b0) rst |-> power_ctl == 5'h1F && osc_run && !in_sleep)
      else $error("reset");
   a_hib_entry: assert property (sleep_req && !in_sleep |=> in_sleep && in_hibernate == $past(sh_q[7]))
      else $error("hibernate");
   a_osc_sleep: assert property (in_sleep && $past(in_sleep) && $stable(sh_q) |-> osc_run == !sh_q[3])
      else $error("osc sleep");
   a_osc_awake: assert property (!in_sleep |-> osc_run) else $error("osc awake");
   a_wake_exit: assert property (in_sleep && wake_req |=> !in_sleep && !in_hibernate) else $error("wake");
   a_sleep_refused: assert property (in_sleep && sleep_req && !wake_req |=> in_sleep && $stable(in_hibernate))
      else $error("sleep refused");
   c_rw: cover property (w ##1 r);
   c_hib: cover property (sleep_req && !in_sleep && sh_q[7]);
   c_stop: cover property (in_sleep && !osc_run);
   c_refused: cover property (in_sleep && sleep_req);
endmodule // sleep_power_control_reg_properties
bind sleep_power_control_reg sleep_power_control_reg_properties u_props (.clock(clock), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .wake_req(wake_req),
   .power_ctl(power_ctl), .osc_run(osc_run), .in_sleep(in_sleep), .in_hibernate(in_hibernate));

// File: verif/sleep_power_control_reg_tb_top.sv
// Testbench for the sleep power control register
`timescale 1ns/1ps
module sleep_power_control_reg_tb_top import sleep_power_pkg::*;;
   logic       clock = 0, rst = 0, wr = 0, rd = 0, sleep_req = 0, wake_req = 0, osc_run, in_sleep, in_hibernate;
   logic [7:0] addr = 0, wdata = 0, rdata;
   logic [7:0] modes [4] = '{8'h08, 8'h00, 8'h80, 8'h88};
   power_ctl_t power_ctl;
   int         failures = 0, n_tests = 0;
   always #12.5 clock = ~clock;
   sleep_power_control_reg u_sleep_power_control_reg (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .wake_req(wake_req), .power_ctl(power_ctl), .osc_run(osc_run),
      .in_sleep(in_sleep), .in_hibernate(in_hibernate));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [7:0] a, logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   // Stored bits to gate outputs, one edge after the write
   task automatic chk_pw(logic [7:0] v);
      @(posedge clock);
      #1 chk("power_ctl", {3'h0, v[5], v[4], v[2], v[1], v[0]}, 8'(power_ctl));
   endtask
   // One sleep entry and wake with a given setting
   task automatic t_sleep(logic [7:0] v);
      wr_reg(8'h8F, v);
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      #1 chk("osc_run", 8'(!v[3]), 8'(osc_run));
      chk("in_hibernate", 8'(v[7]), 8'(in_hibernate));
      chk("in_sleep", 8'h01, 8'(in_sleep));
      @(posedge clock);
      wake_req <= 1'b1;
      @(posedge clock);
      wake_req <= 1'b0;
      #1 chk("osc_run", 8'h01, 8'(osc_run));
      chk("in_sleep", 8'h00, 8'(in_sleep));
      $display("sleep test %h done", v);
   endtask
   // Hibernate, a refused second sleep, then a reset while hibernating
   task automatic t_reset();
      wr_reg(8'h8F, 8'h88);
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      #1 chk("in_hibernate", 8'h01, 8'(in_hibernate));
      @(posedge clock);
      rst <= 1'b1;
      @(posedge clock);
      rst <= 1'b0;
      #1 chk("in_sleep", 8'h00, 8'(in_sleep));
      chk("power_ctl", 8'h1F, 8'(power_ctl));
      rd_reg(8'h8F, 8'h3F);
      $display("reset test 2 done");
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      rst <= 1'b1;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd_reg(8'h8F, 8'h3F);
      chk_pw(8'h3F);
      chk("osc_run", 8'h01, 8'(osc_run));
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h8F, 8'h01 << i);
         chk_pw(8'h01 << i);
         rd_reg(8'h8F, (8'h01 << i) & 8'hBF);
      end
      wr_reg(8'h8E, 8'hFF);
      rd_reg(8'h8E, 8'h00);
      rd_reg(8'h8F, 8'h80);
      $display("field test done");
      foreach (modes[i]) t_sleep(modes[i]);
      t_reset();
      give_verdict();
   end
   initial begin
      repeat (3000) @(posedge clock);
      failures++;
      give_verdict();
   end
endmodule // sleep_power_control_reg_tb_top
